/* File: hw/dsq_pkg.sv */
package dsq_pkg;
  // clock and timing
  localparam int CLK_NS = 25;
  localparam int DLY_STEP_US = 500;
  localparam int DLY_STEP_CYC = DLY_STEP_US * 1000 / CLK_NS;
  localparam int DETECT_CYC = 6;
  localparam int SS_SLOW_NS = 62500;
  localparam int SS_SLOW_CYC = SS_SLOW_NS / CLK_NS;
  localparam int PG_STATIC_NS = 200;
  localparam int PG_STATIC_CYC = PG_STATIC_NS / CLK_NS;
  localparam int CB_STATIC_NS = 400;
  localparam int CB_STATIC_CYC = CB_STATIC_NS / CLK_NS;
  localparam int CHG_DLY_US = 250;
  localparam int CHG_DLY_CYC = CHG_DLY_US * 1000 / CLK_NS;
  localparam int AVG_MS = 80;
  localparam int AVG_SAMPLES = 32;
  localparam int AVG_PACE_CYC = AVG_MS * 1000000 / AVG_SAMPLES / CLK_NS;
  // voltages in 6.25 mV steps
  localparam int TGT_W = 9;
  localparam logic [8:0] BOOT_STEPS = 9'h0A8;
  localparam logic [6:0] UV_BASE = 7'h50;
  localparam logic [6:0] OV_BASE = 7'h30;
  localparam logic [6:0] WIN_STEP = 7'h08;
  localparam logic [8:0] CB_RESET = 9'h030;
  // register map
  localparam int ADDR_W = 8;
  localparam logic [7:0] OFS_DELAY = 8'h00;
  localparam logic [7:0] OFS_SLOPE = 8'h04;
  localparam logic [7:0] OFS_WIN = 8'h08;
  localparam logic [7:0] OFS_STATUS = 8'h0C;
  localparam logic [7:0] OFS_IRQ_STAT = 8'h10;
  localparam logic [7:0] OFS_IRQ_MASK = 8'h14;
  localparam logic [7:0] OFS_MONITOR = 8'h18;
  localparam logic [7:0] OFS_TARGET = 8'h1C;
  localparam int WIN_LO_LSB = 0;
  localparam int WIN_HI_LSB = 4;
  localparam int WIN_AVG_BIT = 8;
  localparam logic [2:0] DELAY_RST = 3'h3;
  localparam logic [2:0] SLOPE_RST = 3'h2;
  localparam logic [2:0] LOWIN_RST = 3'h0;
  localparam logic [1:0] HIWIN_RST = 2'h0;
  // interrupt events
  localparam int EV_W = 4;
  localparam int EV_OK_UP = 0;
  localparam int EV_OK_DOWN = 1;
  localparam int EV_CROWBAR = 2;
  localparam int EV_ABORT = 3;

  typedef enum logic [3:0] {
    ST_IDLE, ST_INIT_DLY, ST_DETECT, ST_BOOT_RAMP, ST_BOOT_HOLD,
    ST_FINAL_RAMP, ST_MASK, ST_OK_BLANK, ST_RUN
  } dsq_state_t;

  // cycles per 6.25 mV step for each slope code
  function automatic logic [11:0] dsq_step_cyc(input logic [2:0] c);
    dsq_step_cyc = 12'(SS_SLOW_CYC / (2 * int'(c) + 1));
  endfunction
endpackage

/* File: hw/dsq_tmr_if.sv */
interface dsq_tmr_if #(parameter int TW = 24);
  logic load;
  logic [TW-1:0] count;
  logic done;
  modport ctl(output load, output count, input done);
  modport tmr(input load, input count, output done);
endinterface

/* File: hw/dsq_timer.sv */
module dsq_timer #(parameter int TW = 24) (
  input wire logic clk,
  input wire logic rst_n,
  input wire logic ce,
  dsq_tmr_if.tmr t
);
  logic [TW-1:0] cnt_ff;

  // reload on request, otherwise count down to zero
  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      cnt_ff <= '0;
    end else if (ce) begin
      if (t.load) begin
        cnt_ff <= t.count;
      end else if (cnt_ff != '0) begin
        cnt_ff <= cnt_ff - 1'b1;
      end
    end
  end

  // a period of n cycles ends on the n-th edge after the load edge
  assign t.done = ce && !t.load && (cnt_ff == TW'(1));
endmodule

/* File: hw/dsq_sequencer.sv */
import dsq_pkg::*;

module dsq_sequencer #(
  parameter int DLY_UNIT_CYC = dsq_pkg::DLY_STEP_CYC,
  parameter int CHG_CYC = dsq_pkg::CHG_DLY_CYC,
  parameter int PACE_CYC = dsq_pkg::AVG_PACE_CYC,
  parameter int TW = 24
) (
  input wire logic pclk,
  input wire logic presetn,
  input wire logic clk_en,
  input wire logic psel,
  input wire logic penable,
  input wire logic pwrite,
  input wire logic [dsq_pkg::ADDR_W-1:0] paddr,
  input wire logic [31:0] pwdata,
  output logic [31:0] prdata,
  output logic pready,
  output logic pslverr,
  input wire logic enable,
  input wire logic supply_lockout,
  input wire logic [7:0] voltage_code,
  input wire logic live_code_change,
  input wire logic [2:0] phase_tied,
  input wire logic [dsq_pkg::TGT_W-1:0] sense_level,
  input wire logic [7:0] adc_sample,
  input wire logic adc_valid,
  output logic adc_start,
  output logic pwm_force_low,
  output logic [2:0] phase_count,
  output logic [dsq_pkg::TGT_W-1:0] dac_target,
  output logic output_ok_flag,
  output logic irq
);
  import dsq_pkg::*;

  // elaboration checks: longest delay and slow counts must fit
  if (DLY_UNIT_CYC < 1 || DLY_UNIT_CYC * 8 >= 2 ** TW) begin : g_chk_dly
    $error("delay unit does not fit timer width");
  end
  if (CHG_CYC < 1 || CHG_CYC >= 2 ** 20) begin : g_chk_chg
    $error("code change delay out of range");
  end
  if (PACE_CYC < 2 || PACE_CYC >= 2 ** 24) begin : g_chk_pace
    $error("monitor pace out of range");
  end

  dsq_state_t state_ff;
  logic [2:0] dly_ff, slope_ff, lowin_ff;
  logic [1:0] hiwin_ff;
  logic avg_en_ff;
  logic [EV_W-1:0] stat_ff, mask_ff, ev;
  logic [TGT_W-1:0] target_ff, code_lat_ff;
  logic [11:0] step_cnt_ff;
  logic [2:0] det_cnt_ff;
  logic [2:0] phase_ff;
  logic ok_ff, cb_ff;
  logic [19:0] pg_cnt_ff, cb_cnt_ff;
  logic [23:0] pace_ff;
  logic [12:0] acc_ff;
  logic [4:0] nsmp_ff;
  logic [7:0] mon_ff;
  logic [31:0] rdata_ff;
  logic err_ff;
  logic go, step_due, uv_bad, ov_bad;
  logic [6:0] uv_off, ov_off;
  logic [19:0] pg_lim, cb_lim;
  logic wr, setup;

  dsq_tmr_if #(.TW(TW)) tmr ();
  dsq_timer #(.TW(TW)) u_timer (
    .clk(pclk),
    .rst_n(presetn),
    .ce(clk_en),
    .t(tmr.tmr)
  );

  assign go = enable && !supply_lockout;
  assign step_due = (step_cnt_ff >= dsq_step_cyc(slope_ff) - 12'h001);

  // timer loads on entry to each delay stage with the current setting
  always_comb begin
    tmr.load = 1'b0;
    unique case (state_ff)
      ST_IDLE: tmr.load = go;
      ST_BOOT_RAMP: tmr.load = go && (target_ff == BOOT_STEPS);
      ST_MASK: tmr.load = go && !live_code_change;
      default: tmr.load = 1'b0;
    endcase
  end
  // delay is (code+1) half-millisecond units
  assign tmr.count = TW'(DLY_UNIT_CYC * (int'(dly_ff) + 1));

  // start-up sequencer
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      state_ff <= ST_IDLE;
    end else if (clk_en) begin
      if (!go) begin
        state_ff <= ST_IDLE;
      end else begin
        unique case (state_ff)
          ST_IDLE: state_ff <= ST_INIT_DLY;
          ST_INIT_DLY: if (tmr.done) begin
            state_ff <= ST_DETECT;
          end
          ST_DETECT: if (det_cnt_ff == 3'(DETECT_CYC - 1)) begin
            state_ff <= ST_BOOT_RAMP;
          end
          ST_BOOT_RAMP: if (target_ff == BOOT_STEPS) begin
            state_ff <= ST_BOOT_HOLD;
          end
          ST_BOOT_HOLD: if (tmr.done) begin
            state_ff <= ST_FINAL_RAMP;
          end
          ST_FINAL_RAMP: if (target_ff == code_lat_ff) begin
            state_ff <= ST_MASK;
          end
          // ok masking ends once the code stops moving
          ST_MASK: if (!live_code_change) begin
            state_ff <= ST_OK_BLANK;
          end
          ST_OK_BLANK: if (tmr.done) begin
            state_ff <= ST_RUN;
          end
          ST_RUN: state_ff <= ST_RUN;
        endcase
      end
    end
  end

  // phase detection window and phase count
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      det_cnt_ff <= 3'h0;
      phase_ff <= 3'h4;
    end else if (clk_en) begin
      if (state_ff != ST_DETECT) begin
        det_cnt_ff <= 3'h0;
      end else begin
        det_cnt_ff <= det_cnt_ff + 3'h1;
        // tied pins drop phases from the top down
        if (det_cnt_ff == 3'(DETECT_CYC - 1)) begin
          phase_ff <= phase_tied[0] ? 3'h1 :
                      phase_tied[1] ? 3'h2 :
                      phase_tied[2] ? 3'h3 : 3'h4;
        end
      end
    end
  end

  // target ramps one 6.25 mV step per slope period
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      target_ff <= '0;
      step_cnt_ff <= 12'h000;
      code_lat_ff <= '0;
    end else if (clk_en) begin
      if (state_ff == ST_IDLE) begin
        target_ff <= '0;
        step_cnt_ff <= 12'h000;
      end else if (state_ff == ST_BOOT_RAMP ||
                   state_ff == ST_FINAL_RAMP) begin
        step_cnt_ff <= step_due ? 12'h000 : step_cnt_ff + 12'h001;
        if (step_due && state_ff == ST_BOOT_RAMP &&
            target_ff != BOOT_STEPS) begin
          target_ff <= target_ff + 9'h001;
        end else if (step_due && state_ff == ST_FINAL_RAMP) begin
          if (target_ff < code_lat_ff) begin
            target_ff <= target_ff + 9'h001;
          end else if (target_ff > code_lat_ff) begin
            target_ff <= target_ff - 9'h001;
          end
        end
      end else begin
        step_cnt_ff <= 12'h000;
      end
      // code is assumed settled by the end of the hold
      if (state_ff == ST_BOOT_HOLD && tmr.done) begin
        code_lat_ff <= {1'b0, voltage_code};
      end
    end
  end

  // window offsets from settings
  assign uv_off = UV_BASE - 7'(WIN_STEP * lowin_ff);
  assign ov_off = OV_BASE - 7'(WIN_STEP * hiwin_ff);
  assign uv_bad = ({1'b0, sense_level} + 10'(uv_off)) < {1'b0, target_ff};
  assign ov_bad = {1'b0, sense_level} > ({1'b0, target_ff} + 10'(ov_off));
  // slower filters while the code moves, to ride through transitions
  assign pg_lim = live_code_change ? 20'(CHG_CYC) :
                  20'(PG_STATIC_CYC);
  assign cb_lim = live_code_change ? 20'(CHG_CYC) :
                  20'(CB_STATIC_CYC);

  // ok flag: set after blanking, dropped after a filtered fault
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      ok_ff <= 1'b0;
      pg_cnt_ff <= 20'h00000;
    end else if (clk_en) begin
      if (state_ff != ST_RUN || !go || cb_ff) begin
        ok_ff <= 1'b0;
        pg_cnt_ff <= 20'h00000;
      end else if (uv_bad || ov_bad) begin
        if (pg_cnt_ff >= pg_lim - 20'h00001) begin
          ok_ff <= 1'b0;
        end else begin
          pg_cnt_ff <= pg_cnt_ff + 20'h00001;
        end
      end else begin
        ok_ff <= 1'b1;
        pg_cnt_ff <= 20'h00000;
      end
    end
  end

  // crowbar: latched until output falls below the reset point
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      cb_ff <= 1'b0;
      cb_cnt_ff <= 20'h00000;
    end else if (clk_en) begin
      if (cb_ff) begin
        cb_cnt_ff <= 20'h00000;
        if (sense_level < CB_RESET) begin
          cb_ff <= 1'b0;
        end
      end else if (ov_bad && state_ff != ST_IDLE) begin
        if (cb_cnt_ff >= cb_lim - 20'h00001) begin
          cb_ff <= 1'b1;
        end else begin
          cb_cnt_ff <= cb_cnt_ff + 20'h00001;
        end
      end else begin
        cb_cnt_ff <= 20'h00000;
      end
    end
  end

  // monitor pacing and 32-sample averaging
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      pace_ff <= 24'h000000;
      acc_ff <= 13'h0000;
      nsmp_ff <= 5'h00;
      mon_ff <= 8'h00;
    end else if (clk_en) begin
      pace_ff <= adc_start ? 24'h000000 : pace_ff + 24'h000001;
      if (adc_valid && !avg_en_ff) begin
        mon_ff <= adc_sample;
      end else if (adc_valid) begin
        nsmp_ff <= nsmp_ff + 5'h01;
        if (nsmp_ff == 5'(AVG_SAMPLES - 1)) begin
          mon_ff <= 8'((acc_ff + 13'(adc_sample)) >> 5);
          acc_ff <= 13'h0000;
        end else begin
          acc_ff <= acc_ff + 13'(adc_sample);
        end
      end
    end
  end
  assign adc_start = clk_en && (pace_ff == 24'(PACE_CYC - 1));

  // events for the interrupt status
  always_comb begin
    ev = '0;
    ev[EV_OK_UP] = !ok_ff && state_ff == ST_RUN && go && !cb_ff &&
                   !uv_bad && !ov_bad;
    ev[EV_OK_DOWN] = ok_ff && (!go || cb_ff || ((uv_bad || ov_bad) &&
                     pg_cnt_ff >= pg_lim - 20'h00001));
    ev[EV_CROWBAR] = !cb_ff && ov_bad && state_ff != ST_IDLE &&
                     cb_cnt_ff >= cb_lim - 20'h00001;
    ev[EV_ABORT] = !go && state_ff != ST_IDLE;
    ev = clk_en ? ev : '0;
  end

  // apb: data captured in setup, answered in the first access cycle
  assign setup = psel && !penable;
  assign wr = psel && penable && pwrite && !err_ff;

  // settings registers
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      dly_ff <= DELAY_RST;
      slope_ff <= SLOPE_RST;
      lowin_ff <= LOWIN_RST;
      hiwin_ff <= HIWIN_RST;
      avg_en_ff <= 1'b0;
      mask_ff <= '0;
    end else if (wr) begin
      if (paddr == OFS_DELAY) begin
        dly_ff <= pwdata[2:0];
      end
      if (paddr == OFS_SLOPE) begin
        slope_ff <= pwdata[2:0];
      end
      if (paddr == OFS_WIN) begin
        lowin_ff <= pwdata[WIN_LO_LSB +: 3];
        hiwin_ff <= pwdata[WIN_HI_LSB +: 2];
        avg_en_ff <= pwdata[WIN_AVG_BIT];
      end
      if (paddr == OFS_IRQ_MASK) begin
        mask_ff <= pwdata[EV_W-1:0];
      end
    end
  end

  // sticky status, write one to clear, a new event wins
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      stat_ff <= '0;
    end else if (wr && paddr == OFS_IRQ_STAT) begin
      stat_ff <= (stat_ff & ~pwdata[EV_W-1:0]) | ev;
    end else begin
      stat_ff <= stat_ff | ev;
    end
  end

  // read data and error captured at setup
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      rdata_ff <= 32'h00000000;
      err_ff <= 1'b0;
    end else if (setup) begin
      err_ff <= 1'b0;
      unique case (paddr)
        OFS_DELAY: rdata_ff <= {29'h0, dly_ff};
        OFS_SLOPE: rdata_ff <= {29'h0, slope_ff};
        OFS_WIN: rdata_ff <= {23'h0, avg_en_ff, 2'h0, hiwin_ff, 1'b0,
                              lowin_ff};
        OFS_STATUS: rdata_ff <= {22'h0, go, phase_ff, cb_ff, ok_ff,
                                 4'(state_ff)};
        OFS_IRQ_STAT: rdata_ff <= {28'h0, stat_ff};
        OFS_IRQ_MASK: rdata_ff <= {28'h0, mask_ff};
        OFS_MONITOR: rdata_ff <= {24'h0, mon_ff};
        OFS_TARGET: rdata_ff <= {23'h0, target_ff};
        default: begin
          rdata_ff <= 32'h00000000;
          err_ff <= 1'b1;
        end
      endcase
    end
  end

  assign prdata = rdata_ff;
  assign pready = 1'b1;
  assign pslverr = psel && penable && err_ff;
  assign irq = |(stat_ff & mask_ff);
  // pwm held low outside regulation or on crowbar
  assign pwm_force_low = cb_ff || state_ff == ST_IDLE ||
                         state_ff == ST_INIT_DLY || state_ff == ST_DETECT;
  assign phase_count = phase_ff;
  assign dac_target = target_ff;
  assign output_ok_flag = ok_ff;

  default clocking cb @(posedge pclk iff clk_en); endclocking
  default disable iff (!presetn);

  sequence s_detect;
    pwm_force_low [*6];
  endsequence
  property p_idle_on_drop;
    !go && state_ff != ST_IDLE |=> state_ff == ST_IDLE && !ok_ff;
  endproperty
  a_idle_on_drop: assert property (p_idle_on_drop)
    else $error("sequencer did not return to idle");
  property p_start;
    state_ff == ST_IDLE && go |-> tmr.load ##1 state_ff == ST_INIT_DLY;
  endproperty
  a_start: assert property (p_start)
    else $error("start did not load the delay timer");
  property p_dly_len;
    tmr.load |-> tmr.count == TW'(DLY_UNIT_CYC * (int'(dly_ff) + 1));
  endproperty
  a_dly_len: assert property (p_dly_len)
    else $error("delay period length wrong");
  property p_detect;
    state_ff == ST_INIT_DLY && tmr.done && go ##1 go [*6] |=>
      $past(pwm_force_low) ##0 state_ff == ST_BOOT_RAMP;
  endproperty
  a_detect: assert property (p_detect)
    else $error("phase detection window not six cycles");
  property p_detect_blank;
    $rose(state_ff == ST_DETECT) |-> s_detect;
  endproperty
  a_detect_blank: assert property (p_detect_blank)
    else $error("pwm not blanked during detection");
  property p_boot;
    state_ff == ST_BOOT_RAMP && target_ff == BOOT_STEPS && go |=>
      state_ff == ST_BOOT_HOLD && target_ff == BOOT_STEPS;
  endproperty
  a_boot: assert property (p_boot)
    else $error("boot voltage not held");
  property p_sample;
    state_ff == ST_BOOT_HOLD && tmr.done && go |=>
      code_lat_ff == {1'b0, $past(voltage_code)};
  endproperty
  a_sample: assert property (p_sample)
    else $error("voltage code not sampled at end of hold");
  property p_step;
    state_ff == ST_FINAL_RAMP && go |=>
      target_ff - $past(target_ff) inside {9'h000, 9'h001, 9'h1FF};
  endproperty
  a_step: assert property (p_step)
    else $error("ramp moved more than one step");
  property p_ok_drop;
    ok_ff && (uv_bad || ov_bad) && pg_cnt_ff >= pg_lim - 20'h00001 |=>
      !ok_ff;
  endproperty
  a_ok_drop: assert property (p_ok_drop)
    else $error("ok flag not dropped after fault delay");
  property p_crowbar;
    cb_ff |-> pwm_force_low && !ok_ff;
  endproperty
  a_crowbar: assert property (p_crowbar)
    else $error("crowbar did not force pwm low");
endmodule

/* File: verif/dsq_cpu_model.sv */
module dsq_cpu_model (
  input wire logic pclk,
  input wire logic presetn,
  input wire logic power_req,
  input wire logic [7:0] code_req,
  input wire logic [7:0] settle_cyc,
  output logic enable,
  output logic [7:0] voltage_code,
  output logic live_code_change
);
  logic [7:0] age_ff;

  // code inverts every cycle until settled, so before the first settle after reset
  // an early sample lands on the wanted value only if that value is 8'h00 or 8'hFF
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      enable <= 1'b0;
      age_ff <= 8'h00;
      voltage_code <= 8'h00;
      live_code_change <= 1'b0;
    end else begin
      enable <= power_req;
      if (!power_req) begin
        age_ff <= 8'h00;
      end else if (age_ff != settle_cyc) begin
        age_ff <= age_ff + 8'h01;
      end
      if (power_req && age_ff == settle_cyc) begin
        voltage_code <= code_req;
        live_code_change <= 1'b0;
      end else begin
        voltage_code <= ~voltage_code;
        live_code_change <= power_req;
      end
    end
  end
endmodule

/* File: verif/dsq_sequencer_tb.sv */
module dsq_sequencer_tb;
  timeunit 1ns;
  timeprecision 1ps;
  import dsq_pkg::*;
  localparam int DU = 20;
  localparam int STEP7 = 2500 / 15;
  logic pclk = 1'b0;
  logic presetn = 1'b0;
  logic psel = 1'b0;
  logic penable = 1'b0;
  logic pwrite = 1'b0;
  logic [7:0] paddr = 8'h00;
  logic [31:0] pwdata = 32'h0;
  logic power_req = 1'b0;
  logic supply_lockout = 1'b0;
  logic adc_valid = 1'b0;
  logic [8:0] sense_level = 9'h000;
  logic [7:0] adc_sample = 8'h00;
  logic [7:0] mon_val = 8'h5A;
  // driven, not tied, but held constant: phase detection sees three phases and clk_en stays high
  logic [2:0] phase_tied = 3'h4;
  logic clk_en = 1'b1;
  logic [31:0] prdata, rd;
  logic pready, pslverr, perr, enable, live_code_change, adc_start;
  logic pwm_force_low, output_ok_flag, irq;
  logic [7:0] voltage_code;
  logic [2:0] phase_count;
  logic [8:0] dac_target;
  int n_mismatch = 0;
  int cmp_count = 0;
  int k;

  always #12.5 pclk = ~pclk;

  // short timer units keep the whole start-up near 30k cycles
  dsq_sequencer #(.DLY_UNIT_CYC(DU), .CHG_CYC(12), .PACE_CYC(10)) dut_u (
    .pclk(pclk), .presetn(presetn), .clk_en(clk_en), .psel(psel),
    .penable(penable), .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata),
    .prdata(prdata), .pready(pready), .pslverr(pslverr), .enable(enable),
    .supply_lockout(supply_lockout), .voltage_code(voltage_code),
    .live_code_change(live_code_change), .phase_tied(phase_tied),
    .sense_level(sense_level), .adc_sample(adc_sample),
    .adc_valid(adc_valid), .adc_start(adc_start),
    .pwm_force_low(pwm_force_low), .phase_count(phase_count),
    .dac_target(dac_target), .output_ok_flag(output_ok_flag), .irq(irq));

  dsq_cpu_model cpu_u (
    .pclk(pclk), .presetn(presetn), .power_req(power_req),
    .code_req(8'hA0), .settle_cyc(8'h64), .enable(enable),
    .voltage_code(voltage_code), .live_code_change(live_code_change));

  // monitor converter answers each start one cycle later
  always @(posedge pclk) begin
    adc_valid <= adc_start;
    adc_sample <= mon_val;
  end

  task automatic chk(input logic [31:0] got, input logic [31:0] exp);
    cmp_count++;
    if (got !== exp) begin
      n_mismatch++;
      $display("MISMATCH t=%0t got=%h exp=%h", $time, got, exp);
    end
  endtask

  // one apb transfer; idle cycle after it avoids double drives
  task automatic apb(input logic [7:0] a, input logic w,
                     input logic [31:0] wd);
    int t;
    t = 0;
    psel <= 1'b1;
    paddr <= a;
    pwrite <= w;
    pwdata <= wd;
    @(posedge pclk);
    penable <= 1'b1;
    do begin
      @(posedge pclk);
      t++;
    end while (pready !== 1'b1 && t < 100);
    if (t >= 100) n_mismatch++;
    rd = prdata;
    perr = pslverr;
    psel <= 1'b0;
    penable <= 1'b0;
    @(posedge pclk);
  endtask

  task automatic rchk(input logic [7:0] a, input logic [31:0] e);
    apb(a, 1'b0, 32'h0);
    chk(rd, e);
  endtask

  task automatic cyc(input int n);
    repeat (n) @(posedge pclk);
  endtask

  task automatic finish_test();
    $display("compares=%0d mismatches=%0d", cmp_count, n_mismatch);
    if (n_mismatch == 0 && cmp_count > 0) begin
      $display("Regression OK");
    end else begin
      $display("Regression broken");
    end
    $finish;
  endtask

  // run needs about 31k cycles
  initial begin
    repeat (70000) @(posedge pclk);
    n_mismatch++;
    finish_test();
  end

  initial begin
    cyc(8);
    presetn <= 1'b1;
    @(posedge pclk);
    chk(32'({pwm_force_low, output_ok_flag, irq}), 32'h4);
    rchk(OFS_DELAY, 32'h3);
    rchk(OFS_SLOPE, 32'h2);
    rchk(OFS_WIN, 32'h0);
    rchk(8'h40, 32'h0);
    chk(32'(perr), 32'h1);
    apb(OFS_DELAY, 1'b1, 32'h0);
    apb(OFS_SLOPE, 1'b1, 32'h7);
    apb(OFS_IRQ_MASK, 1'b1, 32'h1);
    apb(OFS_WIN, 1'b1, 32'h37);
    rchk(OFS_DELAY, 32'h0);
    // start-up: delay, detect, first ramp step
    power_req <= 1'b1;
    k = 0;
    while (dac_target === 9'h000 && k < 400) begin
      @(posedge pclk);
      k++;
    end
    chk(32'(k >= DU + 5 + STEP7 && k <= DU + 11 + STEP7), 32'h1);
    chk(32'(pwm_force_low), 32'h0);
    chk(32'(phase_count), 32'h3);
    apb(OFS_DELAY, 1'b1, 32'h1);
    while (dac_target !== BOOT_STEPS && k < 40000) begin
      @(posedge pclk);
      k++;
    end
    chk(32'(dac_target), 32'(BOOT_STEPS));
    sense_level <= 9'h0A0;
    k = 0;
    while (dac_target === BOOT_STEPS && k < 400) begin
      @(posedge pclk);
      k++;
    end
    chk(32'(k >= 2 * DU), 32'h1);
    chk(32'(dac_target), 32'h0A7);
    while (dac_target !== 9'h0A0 && k < 5000) begin
      @(posedge pclk);
      k++;
    end
    k = 0;
    while (output_ok_flag !== 1'b1 && k < 400) begin
      @(posedge pclk);
      k++;
    end
    chk(32'(k >= 2 * DU && k <= 2 * DU + 8), 32'h1);
    chk(32'(irq), 32'h1);
    apb(OFS_STATUS, 1'b0, 32'h0);
    chk(32'(rd[3:0]), 32'(ST_RUN));
    rchk(OFS_IRQ_STAT, 32'h1);
    apb(OFS_IRQ_STAT, 1'b1, 32'h1);
    chk(32'(irq), 32'h0);
    rchk(OFS_MONITOR, 32'h5A);
    mon_val <= 8'h3C;
    apb(OFS_WIN, 1'b1, 32'h137);
    cyc(800);
    rchk(OFS_MONITOR, 32'h3C);
    apb(OFS_IRQ_MASK, 1'b1, 32'h0);
    // low window at code 7 is 24 steps: 136 holds, 135 trips
    sense_level <= 9'h088;
    cyc(20);
    chk(32'(output_ok_flag), 32'h1);
    sense_level <= 9'h087;
    k = 0;
    while (output_ok_flag === 1'b1 && k < 40) begin
      @(posedge pclk);
      k++;
    end
    chk(32'(k >= 7 && k <= 11), 32'h1);
    chk(32'(irq), 32'h0);
    rchk(OFS_IRQ_STAT, 32'h2);
    apb(OFS_IRQ_MASK, 1'b1, 32'h2);
    chk(32'(irq), 32'h1);
    // high window at code 3 is 24 steps: 184 holds, 185 trips
    sense_level <= 9'h0B8;
    cyc(30);
    chk(32'(pwm_force_low), 32'h0);
    sense_level <= 9'h0B9;
    k = 0;
    while (pwm_force_low !== 1'b1 && k < 60) begin
      @(posedge pclk);
      k++;
    end
    chk(32'(k >= 15 && k <= 19), 32'h1);
    apb(OFS_STATUS, 1'b0, 32'h0);
    chk(32'(rd[5]), 32'h1);
    // ok came back in window before the overvoltage, so ok-up is set again
    rchk(OFS_IRQ_STAT, 32'h7);
    // drop enable mid-run
    power_req <= 1'b0;
    cyc(4);
    chk(32'({pwm_force_low, output_ok_flag, dac_target}), 32'h400);
    rchk(OFS_IRQ_STAT, 32'hF);
    supply_lockout <= 1'b1;
    sense_level <= 9'h000;
    power_req <= 1'b1;
    cyc(60);
    apb(OFS_STATUS, 1'b0, 32'h0);
    chk(32'(rd[3:0]), 32'(ST_IDLE));
    supply_lockout <= 1'b0;
    cyc(4);
    apb(OFS_STATUS, 1'b0, 32'h0);
    chk(32'(rd[3:0]), 32'(ST_INIT_DLY));
    supply_lockout <= 1'b1;
    cyc(3);
    apb(OFS_STATUS, 1'b0, 32'h0);
    chk(32'(rd[3:0]), 32'(ST_IDLE));
    finish_test();
  end
endmodule
